// ---- spsm_pkg.sv ----
// Purpose: Shared constants and types for the serial port slot mapper
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses
// Notes:   Channels 0,1 transmit; 2 receives for the converter path,
//          3 receives for the digital-audio transmitter path
package spsm_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FRAME_LEN = 8'h04;
   localparam logic [7:0] ADDR_TX1_CFG = 8'h08;
   localparam logic [7:0] ADDR_TX2_CFG = 8'h0C;
   localparam logic [7:0] ADDR_RX1_CFG = 8'h10;
   localparam logic [7:0] ADDR_RX2_CFG = 8'h14;
   localparam logic [7:0] ADDR_TX1_DATA = 8'h18;
   localparam logic [7:0] ADDR_TX2_DATA = 8'h1C;
   localparam logic [7:0] ADDR_RX1_DATA = 8'h20;
   localparam logic [7:0] ADDR_RX2_DATA = 8'h24;
   localparam logic [7:0] ADDR_STATUS = 8'h28;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_TX_ISO = 0;
   localparam int CTRL_RX_ISO = 1;
   localparam int CTRL_TX_NSB = 2;
   localparam int CTRL_RX_NSB = 3;
   localparam int CTRL_SPLIT = 4;
   localparam int CTRL_TX_RATE_LSB = 8;
   localparam int CTRL_RX_RATE_LSB = 12;
   localparam int CTRL_TX_FLAG_LSB = 16;
   localparam int CTRL_RX_FLAG_LSB = 20;
   localparam logic [31:0] CTRL_MASK = 32'h0077_771F;
   localparam int CH_START_LSB = 0;
   localparam int CH_WS_LSB = 16;
   localparam int CH_AP_BIT = 20;
   localparam logic [31:0] CH_MASK = 32'h0013_0FFF;
   localparam int STAT_RUN_BIT = 4;
   localparam int STAT_CNT_LSB = 16;

   // ----------------------------------------------------------------
   // Reset values and limits
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CH_RST = 32'h0000_0000;
   localparam logic [12:0] FRAME_MIN = 13'h0010;
   localparam logic [12:0] FRAME_MAX = 13'h1000;
   localparam logic [12:0] FRAME_RST = 13'h0040;
   localparam logic [5:0] WS_STEP = 6'h08;
   localparam logic [5:0] NSB_BITS = 6'h08;
   localparam logic [5:0] MAX_CONV = 6'h18;
   localparam logic [5:0] FULL_WORD = 6'h20;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Stream rate pacing: valid samples per frames
   // ----------------------------------------------------------------
   localparam logic [2:0] RATE_LAST = 3'h5;
   localparam logic [2:0] PACE_NUM [0:5] = '{3'h1, 3'h1, 3'h1, 3'h1,
                                             3'h2, 3'h1};
   localparam logic [2:0] PACE_DEN [0:5] = '{3'h6, 3'h4, 3'h3, 3'h2,
                                             3'h3, 3'h1};

   typedef enum logic [0:0] {
      FR_WAIT = 1'b0,
      FR_RUN = 1'b1
   } spsm_frame_e;

endpackage

// ---- spsm_pace.sv ----
// Purpose: Error accumulator deciding whether a frame carries a sample
// Assumes: step pulses once per frame start
// Notes:   Disabled pacing marks every frame as due
`timescale 1ns/1ns
module spsm_pace
   import spsm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enable,
   input wire logic step,
   input wire logic [2:0] rate,
   output logic due
);

   typedef struct packed {
      logic [2:0] acc;
   } spsm_pace_s;

   spsm_pace_s st_ff;
   spsm_pace_s nxt_st;
   logic [2:0] idx;
   logic [3:0] sum;

   always_comb begin
      nxt_st = st_ff;
      idx = (rate > RATE_LAST) ? RATE_LAST : rate;
      sum = {1'b0, st_ff.acc} + {1'b0, PACE_NUM[idx]};
      due = ~enable | (sum >= {1'b0, PACE_DEN[idx]});
      if (!enable) begin
         nxt_st.acc = 3'h0;
      end else if (step) begin
         // Average rate equals num/den of the frame rate
         if (due) begin
            nxt_st.acc = 3'(sum - {1'b0, PACE_DEN[idx]});
         end else begin
            nxt_st.acc = sum[2:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

// ---- spsm_top.sv ----
// Purpose: Audio serial port slot mapper with isochronous null handling
// Assumes: Host drives bclk and fsync; frame starts at fsync rise
// Notes:   Bit periods run falling edge to falling edge of bclk
`timescale 1ns/1ns
module spsm_top
   import spsm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic bclk,
   input wire logic fsync,
   input wire logic sdin,
   output logic sdout
);

   typedef struct packed {
      logic bclk_m;
      logic bclk_q;
      logic bclk_d;
      logic fsync_m;
      logic fsync_q;
      logic fs_last;
      logic sdin_m;
      logic sdin_q;
      spsm_frame_e fr;
      logic start_pend;
      logic drive;
      logic [12:0] cnt;
      logic [31:0] ctrl;
      logic [12:0] flen;
      logic [3:0][31:0] chcfg;
      logic [1:0][31:0] tx_hold;
      logic [1:0] tx_held;
      logic [1:0][31:0] tx_word;
      logic [1:0][31:0] rx_sh;
      logic [1:0][31:0] rx_data;
      logic [1:0] rx_valid;
      logic sdout;
      logic aw_ok;
      logic [7:0] awaddr;
      logic w_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } spsm_state_s;

   spsm_state_s st_ff;
   spsm_state_s nxt_st;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [5:0] audio_bits(input logic [1:0] ws,
                                             input logic null_indicator_bit_mode);
      logic [5:0] a;
      a = {1'b0, ws, 3'h0} + WS_STEP;
      if (null_indicator_bit_mode && a > MAX_CONV) begin
         a = MAX_CONV;
      end
      return a;
   endfunction

   function automatic logic [31:0] low_mask(input logic [5:0] n);
      if (n >= FULL_WORD) begin
         return 32'hFFFF_FFFF;
      end
      return (32'h1 << n) - 32'h1;
   endfunction

   function automatic logic [31:0] nfs_code(input logic [5:0] n);
      return 32'h1 << (n - 6'h1);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = val[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   logic tx_iso;
   logic rx_iso;
   logic tx_nsb;
   logic rx_nsb;
   logic split;
   logic [2:0] tx_rate;
   logic [2:0] tx_fpos;
   logic [2:0] rx_fpos;
   logic pace_due;
   logic frame_step;

   assign tx_iso = st_ff.ctrl[CTRL_TX_ISO];
   assign rx_iso = st_ff.ctrl[CTRL_RX_ISO];
   assign tx_nsb = st_ff.ctrl[CTRL_TX_NSB] & tx_iso;
   assign rx_nsb = st_ff.ctrl[CTRL_RX_NSB] & rx_iso;
   assign split = st_ff.ctrl[CTRL_SPLIT];
   assign tx_rate = st_ff.ctrl[CTRL_TX_RATE_LSB +: 3];
   assign tx_fpos = st_ff.ctrl[CTRL_TX_FLAG_LSB +: 3];
   assign rx_fpos = st_ff.ctrl[CTRL_RX_FLAG_LSB +: 3];

   // Rate only matters with isochronous transmit enabled
   spsm_pace u_pace (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(tx_iso),
      .step(frame_step),
      .rate(tx_rate),
      .due(pace_due)
   );

   // ----------------------------------------------------------------
   // Slot window decode per channel
   // ----------------------------------------------------------------
   logic [3:0] in_win;
   logic [3:0] last_bit;
   logic [3:0][5:0] wlen_c;
   logic [3:0][5:0] bidx_c;
   logic [3:0] nsb_c;

   for (genvar c = 0; c < 4; c++) begin : g_win
      logic [12:0] half;
      logic phase_hi;
      logic [12:0] pos;
      logic [12:0] idx;
      logic act;
      logic [12:0] start;
      assign half = {1'b0, st_ff.flen[12:1]};
      assign phase_hi = st_ff.cnt >= half;
      assign pos = (split && phase_hi) ? st_ff.cnt - half
         : st_ff.cnt;
      assign act = ~split | (st_ff.chcfg[c][CH_AP_BIT] == phase_hi);
      // Channel 3 feeds the transmitter and stays native
      assign nsb_c[c] = (c < 2) ? tx_nsb
         : ((c == 2) ? rx_nsb : 1'b0);
      assign wlen_c[c] = audio_bits(st_ff.chcfg[c][CH_WS_LSB +: 2], nsb_c[c])
                         + (nsb_c[c] ? NSB_BITS : 6'h0);
      assign start = {1'b0, st_ff.chcfg[c][CH_START_LSB +: 12]};
      assign idx = pos - start;
      assign in_win[c] = (st_ff.fr == FR_RUN) && (st_ff.cnt < st_ff.flen)
                         && act && (pos >= start)
                         && (idx < {7'h0, wlen_c[c]});
      assign last_bit[c] = idx == {7'h0, wlen_c[c] - 6'h1};
      assign bidx_c[c] = wlen_c[c] - 6'h1 - idx[5:0];
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic rise;
   logic fall;
   logic [31:0] w;
   logic [31:0] h;
   logic [5:0] a;
   logic keep;
   logic [31:0] fl;

   always_comb begin
      nxt_st = st_ff;
      frame_step = 1'b0;
      w = 32'h0;
      h = 32'h0;
      a = 6'h0;
      keep = 1'b0;
      fl = 32'h0;
      nxt_st.bclk_m = bclk;
      nxt_st.bclk_q = st_ff.bclk_m;
      nxt_st.bclk_d = st_ff.bclk_q;
      nxt_st.fsync_m = fsync;
      nxt_st.fsync_q = st_ff.fsync_m;
      nxt_st.sdin_m = sdin;
      nxt_st.sdin_q = st_ff.sdin_m;
      rise = st_ff.bclk_q & ~st_ff.bclk_d;
      fall = ~st_ff.bclk_q & st_ff.bclk_d;
      nxt_st.drive = fall;

      // Register read; a sample landing this cycle keeps valid set
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (st_ff.arready && s_axi_arvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
            ADDR_FRAME_LEN: nxt_st.rdata = {19'h0, st_ff.flen};
            ADDR_TX1_CFG: nxt_st.rdata = st_ff.chcfg[0];
            ADDR_TX2_CFG: nxt_st.rdata = st_ff.chcfg[1];
            ADDR_RX1_CFG: nxt_st.rdata = st_ff.chcfg[2];
            ADDR_RX2_CFG: nxt_st.rdata = st_ff.chcfg[3];
            ADDR_TX1_DATA: nxt_st.rdata = st_ff.tx_hold[0];
            ADDR_TX2_DATA: nxt_st.rdata = st_ff.tx_hold[1];
            ADDR_RX1_DATA: begin
               nxt_st.rdata = st_ff.rx_data[0];
               nxt_st.rx_valid[0] = 1'b0;
            end
            ADDR_RX2_DATA: begin
               nxt_st.rdata = st_ff.rx_data[1];
               nxt_st.rx_valid[1] = 1'b0;
            end
            ADDR_STATUS: begin
               nxt_st.rdata = 32'h0;
               nxt_st.rdata[1:0] = st_ff.tx_held;
               nxt_st.rdata[3:2] = st_ff.rx_valid;
               nxt_st.rdata[STAT_RUN_BIT] = st_ff.fr == FR_RUN;
               nxt_st.rdata[STAT_CNT_LSB +: 13] = st_ff.cnt;
            end
            default: begin
               nxt_st.rdata = 32'h0;
               nxt_st.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Receive: sample on bclk rise within the slot
      if (rise) begin
         nxt_st.fs_last = st_ff.fsync_q;
         if (st_ff.fsync_q && !st_ff.fs_last) begin
            nxt_st.start_pend = 1'b1;
         end
         for (int c = 0; c < 2; c++) begin
            if (in_win[c+2]) begin
               w = {st_ff.rx_sh[c][30:0], st_ff.sdin_q};
               nxt_st.rx_sh[c] = w;
               if (last_bit[c+2]) begin
                  w = w & low_mask(wlen_c[c+2]);
                  keep = 1'b1;
                  // Removal ignores the programmed rate
                  if (c == 0 && rx_nsb) begin
                     keep = w[rx_fpos];
                     w = w >> NSB_BITS;
                  end else if (c == 0 && rx_iso) begin
                     keep = w != nfs_code(wlen_c[c+2]);
                  end
                  if (c == 0 && !rx_nsb && wlen_c[c+2] == FULL_WORD) begin
                     w = w >> NSB_BITS;
                  end
                  if (keep) begin
                     nxt_st.rx_data[c] = w;
                     nxt_st.rx_valid[c] = 1'b1;
                  end
               end
            end
         end
      end

      // Frame timing and transmit word load on bclk fall
      if (fall) begin
         if (st_ff.start_pend) begin
            nxt_st.start_pend = 1'b0;
            nxt_st.fr = FR_RUN;
            nxt_st.cnt = 13'h0;
            frame_step = 1'b1;
            for (int c = 0; c < 2; c++) begin
               a = audio_bits(st_ff.chcfg[c][CH_WS_LSB +: 2], tx_nsb);
               h = st_ff.tx_hold[c];
               if (a == FULL_WORD) begin
                  h = {h[31:8], 8'h00};
               end else begin
                  h = h & low_mask(a);
               end
               if (tx_iso && !tx_nsb && h == nfs_code(a)) begin
                  h = h + 32'h1;
               end
               if (tx_nsb) begin
                  h = (h << NSB_BITS) | (32'h1 << tx_fpos);
               end
               if (tx_iso && (!pace_due || !st_ff.tx_held[c])) begin
                  // Null at full transported width
                  nxt_st.tx_word[c] = nfs_code(wlen_c[c]);
               end else if (st_ff.tx_held[c]) begin
                  nxt_st.tx_word[c] = h;
                  nxt_st.tx_held[c] = 1'b0;
               end else begin
                  nxt_st.tx_word[c] = 32'h0;
               end
            end
         end else if (st_ff.fr == FR_RUN && st_ff.cnt < st_ff.flen) begin
            nxt_st.cnt = st_ff.cnt + 13'h1;
         end
      end

      // Drive the bit for the period just begun, MSB first
      if (st_ff.drive) begin
         if (in_win[0]) begin
            nxt_st.sdout = st_ff.tx_word[0][bidx_c[0][4:0]];
         end else if (in_win[1]) begin
            nxt_st.sdout = st_ff.tx_word[1][bidx_c[1][4:0]];
         end else begin
            nxt_st.sdout = 1'b0;
         end
      end

      // Register write
      if (st_ff.awready && s_axi_awvalid) begin
         nxt_st.aw_ok = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (st_ff.wready && s_axi_wvalid) begin
         nxt_st.w_ok = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid) begin
         nxt_st.aw_ok = 1'b0;
         nxt_st.w_ok = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         case (st_ff.awaddr)
            ADDR_CTRL: begin
               nxt_st.ctrl = merge(st_ff.ctrl, st_ff.wdata, st_ff.wstrb)
                             & CTRL_MASK;
            end
            ADDR_FRAME_LEN: begin
               fl = merge({19'h0, st_ff.flen}, st_ff.wdata, st_ff.wstrb);
               if (fl > {19'h0, FRAME_MAX}) begin
                  nxt_st.flen = FRAME_MAX;
               end else if (fl < {19'h0, FRAME_MIN}) begin
                  nxt_st.flen = FRAME_MIN;
               end else begin
                  nxt_st.flen = fl[12:0];
               end
            end
            ADDR_TX1_CFG, ADDR_TX2_CFG, ADDR_RX1_CFG, ADDR_RX2_CFG: begin
               nxt_st.chcfg[st_ff.awaddr[4:2] - 3'h2] =
                  merge(st_ff.chcfg[st_ff.awaddr[4:2] - 3'h2],
                        st_ff.wdata, st_ff.wstrb) & CH_MASK;
            end
            ADDR_TX1_DATA, ADDR_TX2_DATA: begin
               nxt_st.tx_hold[st_ff.awaddr[2]] =
                  merge(st_ff.tx_hold[st_ff.awaddr[2]],
                        st_ff.wdata, st_ff.wstrb);
               nxt_st.tx_held[st_ff.awaddr[2]] = 1'b1;
            end
            ADDR_RX1_DATA, ADDR_RX2_DATA, ADDR_STATUS: begin
               nxt_st.bresp = RESP_OKAY;
            end
            default: begin
               nxt_st.bresp = RESP_SLVERR;
            end
         endcase
      end
      nxt_st.awready = ~nxt_st.aw_ok & ~nxt_st.bvalid;
      nxt_st.wready = ~nxt_st.w_ok & ~nxt_st.bvalid;
      nxt_st.arready = ~nxt_st.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.ctrl <= CTRL_RST;
         st_ff.flen <= FRAME_RST;
         st_ff.chcfg <= {4{CH_RST}};
         st_ff.fr <= FR_WAIT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign sdout = st_ff.sdout;

endmodule

// ---- spsm_top_asserts.sv ----
// Purpose: Port checks for spsm_top
// Assumes: One clock domain, reset active low
// Notes: Bound to every spsm_top instance
`timescale 1ns/1ns
module spsm_top_chk
   import spsm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic sdout
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_b_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   chk_r_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_ar_block: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("arready during rvalid");
   chk_w_block: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready during bvalid");
   chk_read_lat: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_write_lat: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   chk_unmap_err: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > ADDR_STATUS[7:2]
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_bit_hold: assert property (
      $changed(sdout) |=> $stable(sdout) [*4])
      else $error("serial bit too short");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   cover property ($rose(sdout));
endmodule
bind spsm_top spsm_top_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sdout);

// ---- spsm_host.sv ----
// Purpose: Host side of the audio serial link
// Assumes: Frame of 64 bit periods, 48 ns bit clock
// Notes: Bit clock stands low between frames
`timescale 1ns/1ns
module spsm_host (
   output logic bclk,
   output logic fsync,
   output logic sdin,
   input wire logic sdout,
   output logic [63:0] cap
);
   // ------------------------------------------------------------
   // Frame driver
   // ------------------------------------------------------------
   initial begin
      bclk = 1'b0;
      fsync = 1'b0;
      sdin = 1'b0;
      cap = 64'h0;
   end
   // One frame, data MSB first, sdout captured
   task automatic run(input logic [63:0] din);
      // Keep link edges off the system clock edge
      #1;
      fsync = 1'b1;
      #24 bclk = 1'b1;
      #24 bclk = 1'b0;
      for (int p = 0; p < 64; p++) begin
         fsync = 1'b0;
         sdin = din[63-p];
         #24 bclk = 1'b1;
         cap = {cap[62:0], sdout};
         #24 bclk = 1'b0;
      end
      // Released line shows the inverse
      sdin = ~sdin;
   endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for spsm_top
// Assumes: Host model drives the link
// Notes: Frame length left at 64
`timescale 1ns/1ns
module tb_top
   import spsm_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, bclk, fsync, sdin, sdout;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [63:0] cap, x;
   int fails = 0, tests_run = 0, v;
   int exp_v [5] = '{2, 3, 4, 6, 8};
   always #2 aclk = ~aclk;
   spsm_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .bclk, .fsync, .sdin,
      .sdout);
   spsm_host host (.bclk, .fsync, .sdin, .sdout, .cap);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("counts: %0d run, %0d failed", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, s);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 99; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            return;
         end
      end
      fails++;
      results();
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 99; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            return;
         end
      end
      fails++;
      results();
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk("read", {30'h0, RESP_OKAY, e}, {30'h0, r, d});
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rc(ADDR_CTRL, CTRL_RST);
      rc(ADDR_FRAME_LEN, 32'(FRAME_RST));
      rd(8'h30);
      chk("unmapped", {30'h0, RESP_SLVERR, 32'h0}, {30'h0, r, d});
      wr(ADDR_FRAME_LEN, 32'h8);
      rc(ADDR_FRAME_LEN, 32'(FRAME_MIN));
      wr(ADDR_FRAME_LEN, 32'h2000);
      rc(ADDR_FRAME_LEN, 32'(FRAME_MAX));
      wr(ADDR_FRAME_LEN, 32'(FRAME_RST));
      $display("registers done");
      wr(ADDR_TX2_CFG, 32'd48);
      for (int i = 0; i < 4; i++) begin
         v = (i == 3) ? 24 : 8 * i + 8;
         wr(ADDR_TX1_CFG, 32'(i << CH_WS_LSB | i));
         wr(ADDR_TX1_DATA, 32'hFFFF_FFFF);
         host.run(64'h0);
         x = ((64'h1 << v) - 1) << (64 - i - v);
         chk("tx size", x, cap);
      end
      $display("native transmit done");
      wr(ADDR_TX1_CFG, 32'h0001_0000);
      for (int c = 0; c < 5; c++) begin
         wr(ADDR_CTRL, 32'(c << CTRL_TX_RATE_LSB | 3));
         v = 0;
         for (int f = 0; f < 12; f++) begin
            wr(ADDR_TX1_DATA, 32'h8000_8000);
            host.run(64'h0);
            if (cap[63:48] !== 16'h8000) begin
               v++;
               chk("tx bump", 64'h8001, 64'(cap[63:48]));
            end
         end
         chk("tx rate", 64'(exp_v[c]), 64'(v));
      end
      wr(ADDR_CTRL, 32'h0000_0707);
      wr(ADDR_TX1_DATA, 32'h8000_8000);
      host.run(64'h0);
      chk("tx flag", 64'h1_0001, 64'({cap[63:48], cap[40]}));
      $display("isochronous transmit done");
      wr(ADDR_RX1_CFG, 32'h0001_0000);
      wr(ADDR_CTRL, 32'h0000_5003);
      // Drain samples kept by earlier frames
      rd(ADDR_RX1_DATA);
      host.run({16'h8000, 48'h0});
      rd(ADDR_STATUS);
      chk("rx null", 64'h0, 64'(d[2]));
      rc(ADDR_RX2_DATA, 32'h0000_0080);
      host.run({16'h1234, 48'h0});
      rc(ADDR_RX1_DATA, 32'h0000_1234);
      wr(ADDR_CTRL, 32'h0030_000B);
      host.run({16'h5555, 8'hF7, 40'h0});
      rd(ADDR_STATUS);
      chk("rx flag clear", 64'h0, 64'(d[2]));
      host.run({16'hBEEF, 8'h08, 40'h0});
      rc(ADDR_RX1_DATA, 32'h0000_BEEF);
      $display("receive done");
      wr(ADDR_CTRL, 32'h0000_0010);
      wr(ADDR_TX1_CFG, 32'h0010_0002);
      wr(ADDR_TX1_DATA, 32'h0000_00A5);
      host.run(64'h0);
      chk("split", 64'hA5 << 22, cap);
      $display("split phase done");
      results();
   end
endmodule
